// ---- verilog/tif_pkg.sv ----
package tif_pkg;
  // Channel count and per-channel source layout.
  localparam int NUM_CH = 6;
  localparam int NUM_GR = 4;
  localparam int CNT_W = 16;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 4;

  // Register indices; byte address is four times the index.
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] REG_ENABLE = 4'h1;
  localparam logic [ADDR_W-1:0] REG_IRQ = 4'h2;
  localparam logic [ADDR_W-1:0] REG_LEVEL = 4'h3;
  localparam logic [ADDR_W-1:0] REG_PINS = 4'h4;
  localparam logic [ADDR_W-1:0] REG_TRIG = 4'h5;

  // Per-channel 8-bit field: bits 0..3 capture/compare A..D, 4 overflow, 5 underflow.
  // Enable field adds bit 7 for the converter trigger enable.
  localparam int FLD_W = 8;
  localparam int BIT_OVF = 4;
  localparam int BIT_UDF = 5;
  localparam int BIT_TRG = 7;
  localparam logic [FLD_W-1:0] RESET_FIELD = 8'h00;

  // Source masks: channels 0 and 3 have A..D and overflow, others A, B, both.
  localparam logic [FLD_W-1:0] MASK_FULL = 8'h1f;
  localparam logic [FLD_W-1:0] MASK_PAIR = 8'h33;
  localparam logic [FLD_W-1:0] MASK_EN_FULL = 8'h9f;
  localparam logic [FLD_W-1:0] MASK_EN_PAIR = 8'hb3;

  // Events from the counting logic of one channel.
  typedef struct packed {
    logic [NUM_GR-1:0] capture; // Input capture strobes A..D.
    logic tick;                 // Counter input clock pulse.
    logic overflow;             // Counter overflow.
    logic underflow;            // Counter underflow.
    logic clear;                // Counter clear in this cycle.
  } tif_event_type;

  // Per-channel outputs toward the interrupt controller.
  typedef struct packed {
    logic [NUM_GR-1:0] cc_irq;
    logic ovf_irq;
    logic udf_irq;
  } tif_irq_type;
endpackage

// ---- verilog/tif_compare.sv ----
`timescale 1ns/1ns
`default_nettype none
// Compare match for one general register, with pin level on match.
module tif_compare (
  input wire logic mclk, // Clock.
  input wire logic reset, // Synchronous reset.
  input wire logic clk_en, // Clock enable.
  input wire logic [tif_pkg::CNT_W-1:0] count, // Channel counter value.
  input wire logic [tif_pkg::CNT_W-1:0] general_register, // Compare value.
  input wire logic tick, // Counter input clock pulse.
  input wire logic out_level, // Level to drive on match.
  output logic match, // Compare match strobe.
  output logic pin_out // Output compare pin.
);
  logic armed;

  // Last matched state
  // The match fires while the counter still equals the register and is about
  // to be updated by the tick; that is the last state of the equality.
  // One match per tick
  assign match = armed && tick && (count == general_register);

  // After a match the comparator waits for the next counter clock pulse.
  always_ff @(posedge mclk) begin
    if (reset) begin
      armed <= 1'b1;
    end else if (clk_en) begin
      if (match) begin
        armed <= 1'b0;
      end else if (tick) begin
        armed <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      pin_out <= 1'b0;
    end else if (clk_en && match) begin
      pin_out <= out_level;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/tif_flags.sv ----
`timescale 1ns/1ns
`default_nettype none
module tif_flags (
  input wire logic mclk, // Clock, 25 MHz.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic clk_en, // Clock enable; low freezes all state.
  input wire logic [tif_pkg::ADDR_W-1:0] avs_address, // Word index.
  input wire logic avs_read, // Read request.
  input wire logic avs_write, // Write request.
  input wire logic [tif_pkg::DATA_W-1:0] avs_writedata, // Write data.
  input wire logic [3:0] avs_byteenable, // Byte lanes.
  output logic [tif_pkg::DATA_W-1:0] avs_readdata, // Read data, registered.
  output logic avs_waitrequest, // Wait request.
  input wire tif_pkg::tif_event_type [tif_pkg::NUM_CH-1:0] events, // Counter events.
  input wire logic [tif_pkg::NUM_CH*tif_pkg::NUM_GR*tif_pkg::CNT_W-1:0] gr_values, // Registers.
  input wire logic [tif_pkg::NUM_CH*tif_pkg::CNT_W-1:0] counts, // Channel counters.
  output tif_pkg::tif_irq_type [tif_pkg::NUM_CH-1:0] irqs, // Interrupt requests.
  output logic [tif_pkg::NUM_CH-1:0] adc_start, // Conversion start pulses.
  output logic [tif_pkg::NUM_CH*tif_pkg::NUM_GR-1:0] compare_pins // Compare pins.
);
  localparam int NFLAT = tif_pkg::NUM_CH * tif_pkg::FLD_W;

  logic [NFLAT-1:0] flag_status_reg;
  logic [NFLAT-1:0] interrupt_enable_reg;
  logic [NFLAT-1:0] read_as_one;
  logic [tif_pkg::NUM_CH*tif_pkg::NUM_GR-1:0] io_control_reg;
  logic [tif_pkg::NUM_CH*tif_pkg::NUM_GR-1:0] match;
  logic [NFLAT-1:0] set_ev;
  logic [NFLAT-1:0] src_mask;
  logic [NFLAT-1:0] en_mask;
  logic [NFLAT-1:0] wr_mask;
  logic [NFLAT-1:0] wr_data;
  logic [NFLAT-1:0] next_flags;
  logic [tif_pkg::NUM_CH-1:0] chan_a_set;
  logic ack;
  logic wr_status;
  logic wr_enable;
  logic wr_level;
  logic rd_status;

  // Answer in the cycle after the request; one wait cycle keeps read data registered.
  always_ff @(posedge mclk) begin
    if (reset) begin
      ack <= 1'b0;
    end else if (clk_en) begin
      ack <= (avs_read || avs_write) && !ack;
    end
  end
  assign avs_waitrequest = (avs_read || avs_write) && !ack;

  // Status and enable decode ignore bit 3, so the mirrored upper word reaches channels 4 and 5.
  // The read-as-one record is taken at the edge that loads read data, so it matches what was read.
  assign wr_status = clk_en && ack && avs_write
    && (avs_address[2:0] == tif_pkg::REG_STATUS[2:0]);
  assign wr_enable = clk_en && ack && avs_write
    && (avs_address[2:0] == tif_pkg::REG_ENABLE[2:0]);
  assign wr_level = clk_en && ack && avs_write && (avs_address == tif_pkg::REG_LEVEL);
  assign rd_status = clk_en && !ack && avs_read
    && (avs_address[2:0] == tif_pkg::REG_STATUS[2:0]);

  // Byte lanes cover the low 32 bits; channels 4 and 5 sit in a wider field.
  // Both status and enable span 48 bits, so the upper channels use the low
  // lanes of a mirrored word at index plus eight.
  genvar ch;
  generate
    for (ch = 0; ch < tif_pkg::NUM_CH; ch = ch + 1) begin : g_ch
      localparam bit FULL = (ch == 0) || (ch == 3);
      localparam int LO = ch * tif_pkg::FLD_W;
      localparam int LANE = ch % 4;
      logic hi_sel;
      logic lane_ok;
      assign src_mask[LO +: tif_pkg::FLD_W] = FULL ? tif_pkg::MASK_FULL : tif_pkg::MASK_PAIR;
      assign en_mask[LO +: tif_pkg::FLD_W] = FULL ? tif_pkg::MASK_EN_FULL : tif_pkg::MASK_EN_PAIR;
      assign hi_sel = (ch >= 4);
      assign lane_ok = avs_byteenable[LANE] && (avs_address[3] == hi_sel);
      assign wr_mask[LO +: tif_pkg::FLD_W] = {tif_pkg::FLD_W{lane_ok}};
      assign wr_data[LO +: tif_pkg::FLD_W] = avs_writedata[LANE*8 +: 8];

      assign set_ev[LO +: tif_pkg::FLD_W] = {2'b00,
        events[ch].underflow && !events[ch].clear,
        events[ch].overflow && !events[ch].clear,
        match[ch*4 +: 4] | events[ch].capture} & src_mask[LO +: tif_pkg::FLD_W];

      assign irqs[ch].cc_irq = flag_status_reg[LO +: 4] & interrupt_enable_reg[LO +: 4];
      assign irqs[ch].ovf_irq = flag_status_reg[LO + tif_pkg::BIT_OVF]
        && interrupt_enable_reg[LO + tif_pkg::BIT_OVF];
      assign irqs[ch].udf_irq = flag_status_reg[LO + tif_pkg::BIT_UDF]
        && interrupt_enable_reg[LO + tif_pkg::BIT_UDF];

      assign chan_a_set[ch] = set_ev[LO] && !flag_status_reg[LO];
      always_ff @(posedge mclk) begin
        if (reset) begin
          adc_start[ch] <= 1'b0;
        end else if (clk_en) begin
          adc_start[ch] <= chan_a_set[ch] && interrupt_enable_reg[LO + tif_pkg::BIT_TRG];
        end
      end

      for (genvar g = 0; g < tif_pkg::NUM_GR; g = g + 1) begin : g_gr
        localparam int K = ch * tif_pkg::NUM_GR + g;
        if (FULL || g < 2) begin : g_on
          tif_compare u_cmp (
            .mclk(mclk),
            .reset(reset),
            .clk_en(clk_en),
            .count(counts[ch*tif_pkg::CNT_W +: tif_pkg::CNT_W]),
            .general_register(gr_values[K*tif_pkg::CNT_W +: tif_pkg::CNT_W]),
            .tick(events[ch].tick),
            .out_level(io_control_reg[K]),
            .match(match[K]),
            .pin_out(compare_pins[K])
          );
        end else begin : g_off
          assign match[K] = 1'b0;
          assign compare_pins[K] = 1'b0;
        end
      end
    end
  endgenerate

  always_comb begin
    next_flags = flag_status_reg;
    if (wr_status) begin
      next_flags = flag_status_reg & ~(wr_mask & ~wr_data & read_as_one);
    end
    next_flags = (next_flags | set_ev) & src_mask;
  end

  // Status flags; a set in the clearing cycle wins.
  always_ff @(posedge mclk) begin
    if (reset) begin
      flag_status_reg <= {tif_pkg::NUM_CH{tif_pkg::RESET_FIELD}};
    end else if (clk_en) begin
      flag_status_reg <= next_flags;
    end
  end

  // Remember which flags were seen as one; a clear attempt consumes them.
  always_ff @(posedge mclk) begin
    if (reset) begin
      read_as_one <= {tif_pkg::NUM_CH{tif_pkg::RESET_FIELD}};
    end else if (clk_en) begin
      if (rd_status) begin
        read_as_one <= read_as_one | (flag_status_reg & wr_mask_rd(avs_address[3]));
      end else if (wr_status) begin
        read_as_one <= read_as_one & ~(wr_mask & ~wr_data);
      end
    end
  end

  // Lane selection for reads: low word holds channels 0..3, high word 4..5.
  function automatic logic [NFLAT-1:0] wr_mask_rd(input logic hi);
    logic [NFLAT-1:0] m;
    m = '0;
    for (int i = 0; i < tif_pkg::NUM_CH; i++) begin
      m[i*tif_pkg::FLD_W +: tif_pkg::FLD_W] = {tif_pkg::FLD_W{(i >= 4) == hi}};
    end
    return m;
  endfunction

  always_ff @(posedge mclk) begin
    if (reset) begin
      interrupt_enable_reg <= {tif_pkg::NUM_CH{tif_pkg::RESET_FIELD}};
    end else if (wr_enable) begin
      interrupt_enable_reg <= ((interrupt_enable_reg & ~wr_mask) | (wr_data & wr_mask)) & en_mask;
    end
  end

  // Output levels for the compare pins, one bit per general register.
  always_ff @(posedge mclk) begin
    if (reset) begin
      io_control_reg <= '0;
    end else if (wr_level) begin
      io_control_reg <= avs_writedata[tif_pkg::NUM_CH*tif_pkg::NUM_GR-1:0];
    end
  end

  // Registered read data; unmapped indices read as zero.
  always_ff @(posedge mclk) begin
    if (reset) begin
      avs_readdata <= '0;
    end else if (clk_en && avs_read && !ack) begin
      unique case (avs_address[2:0])
        tif_pkg::REG_STATUS[2:0]: avs_readdata <= avs_address[3] ?
          {16'h0000, flag_status_reg[NFLAT-1:32]} : flag_status_reg[31:0];
        tif_pkg::REG_ENABLE[2:0]: avs_readdata <= avs_address[3] ?
          {16'h0000, interrupt_enable_reg[NFLAT-1:32]} : interrupt_enable_reg[31:0];
        tif_pkg::REG_IRQ[2:0]: avs_readdata <= avs_address[3] ?
          {20'h00000, irqs[5:4]} : {8'h00, irqs[3:0]};
        tif_pkg::REG_LEVEL[2:0]: avs_readdata <= avs_address[3] ? '0 : {8'h00, io_control_reg};
        tif_pkg::REG_PINS[2:0]: avs_readdata <= avs_address[3] ? '0 : {8'h00, compare_pins};
        tif_pkg::REG_TRIG[2:0]: avs_readdata <= avs_address[3] ? '0 : {26'h0000000, adc_start};
        default: avs_readdata <= '0;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- sim/tif_flags_checker.sv ----
`timescale 1ns/1ns
`default_nettype none
// Ties bus answers, requests, starts and pins to their causes.
module tif_flags_checker (
  input wire logic mclk, // Clock.
  input wire logic reset, // Reset.
  input wire logic avs_read, // Read.
  input wire logic avs_write, // Write.
  input wire logic avs_waitrequest, // Wait.
  input wire tif_pkg::tif_event_type [tif_pkg::NUM_CH-1:0] events, // Events.
  input wire logic [tif_pkg::NUM_CH*tif_pkg::NUM_GR*tif_pkg::CNT_W-1:0] gr_values, // Registers.
  input wire logic [tif_pkg::NUM_CH*tif_pkg::CNT_W-1:0] counts, // Counters.
  input wire tif_pkg::tif_irq_type [tif_pkg::NUM_CH-1:0] irqs, // Requests.
  input wire logic [tif_pkg::NUM_CH-1:0] adc_start, // Starts.
  input wire logic [tif_pkg::NUM_CH*tif_pkg::NUM_GR-1:0] compare_pins // Pins.
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  property p_ack; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("bus answer late");
  property p_new; (avs_read || avs_write) && !$past(avs_read || avs_write) |-> avs_waitrequest;
  endproperty
  a_new: assert property (p_new) else $error("bus answered at once");
  property p_absent; !irqs[0].udf_irq && !irqs[3].udf_irq && irqs[1].cc_irq[3:2] == 2'b00;
  endproperty
  a_absent: assert property (p_absent) else $error("absent source raised");
  property p_cc; $rose(irqs[1].cc_irq[0]) |-> $past(events[1].capture[0] || events[1].tick)
    || $past(avs_write); endproperty
  a_cc: assert property (p_cc) else $error("request without cause");
  property p_drop; $fell(irqs[0].ovf_irq) |-> $past(avs_write); endproperty
  a_drop: assert property (p_drop) else $error("request dropped alone");
  property p_adc; adc_start[0] |-> $past(events[0].capture[0] || events[0].tick); endproperty
  a_adc: assert property (p_adc) else $error("start without channel A event");
  property p_adc_one; adc_start[1] |=> !adc_start[1]; endproperty
  a_adc_one: assert property (p_adc_one) else $error("start pulse too long");
  property p_pin; compare_pins[0] != $past(compare_pins[0]) |->
    $past(events[0].tick && counts[15:0] == gr_values[15:0]); endproperty
  a_pin: assert property (p_pin) else $error("pin moved without match");
  property p_ovf_clr; events[1].overflow && events[1].clear && !irqs[1].ovf_irq && !avs_write
    |=> !irqs[1].ovf_irq; endproperty
  a_ovf_clr: assert property (p_ovf_clr) else $error("overflow set during clear");
endmodule
bind tif_flags tif_flags_checker u_chk (.mclk(mclk), .reset(reset), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .events(events),
  .gr_values(gr_values), .counts(counts), .irqs(irqs), .adc_start(adc_start),
  .compare_pins(compare_pins));
`default_nettype wire

// ---- sim/tif_adc_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// Converter side: counts conversions begun from timer start requests.
module tif_adc_model (
  input wire logic mclk, // Clock.
  input wire logic reset, // Reset.
  input wire logic [5:0] adc_start, // Start requests.
  input wire logic accept, // Timer unit selected as trigger.
  output logic [7:0] n_conv // Conversions begun.
);
  always_ff @(posedge mclk) begin
    if (reset) begin
      n_conv <= 8'h00;
    end else if (accept) begin
      n_conv <= n_conv + 8'($countones(adc_start));
    end
  end
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  tif_pkg::tif_event_type [5:0] events = '0;
  logic [383:0] gr_values = '0;
  logic [95:0] counts = '0;
  tif_pkg::tif_irq_type [5:0] irqs;
  logic [5:0] adc_start;
  logic [23:0] compare_pins;
  logic accept = 1'b1;
  logic [7:0] n_conv;
  logic [31:0] rd;
  int n_mismatch = 0;
  int checks = 0;
  // Clock of 40 ns.
  always #20 mclk = ~mclk;
  tif_flags dut (.mclk(mclk), .reset(reset), .clk_en(clk_en), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .events(events), .gr_values(gr_values),
    .counts(counts), .irqs(irqs), .adc_start(adc_start), .compare_pins(compare_pins));
  tif_adc_model adc (.mclk(mclk), .reset(reset), .adc_start(adc_start), .accept(accept),
    .n_conv(n_conv));
  task automatic finish_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One bus access; held until waitrequest is seen low, with the wait bounded at 20 edges.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
    input logic [3:0] be);
    int i;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 20);
    if (i >= 20) begin
      n_mismatch++;
      finish_test();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Events last one cycle; one more edge lets flags and pins land.
  task automatic pulse(input logic [47:0] v);
    @(posedge mclk);
    events <= v;
    @(posedge mclk);
    events <= '0;
    @(posedge mclk);
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    bus(0, tif_pkg::REG_STATUS, 0, 4'hf);
    chk("status reset", 32'h0, rd);
    bus(1, tif_pkg::REG_ENABLE, 32'hffffffff, 4'hf);
    bus(1, 4'h9, 32'hffffffff, 4'hf);
    bus(0, tif_pkg::REG_ENABLE, 0, 4'hf);
    chk("enable low", 32'h9fb3b39f, rd);
    bus(0, 4'h9, 0, 4'hf);
    chk("enable high", 32'h0000b3b3, rd);
    pulse({6{8'hf6}});
    bus(0, tif_pkg::REG_STATUS, 0, 4'hf);
    chk("status low", 32'h1f33331f, rd);
    bus(0, 4'h8, 0, 4'hf);
    chk("status high", 32'h00003333, rd);
    chk("irq ch1", 32'h0f, {26'h0, irqs[1]});
    chk("conversions", 32'h6, {24'h0, n_conv});
    bus(1, tif_pkg::REG_STATUS, 32'hffffffff, 4'hf);
    bus(1, tif_pkg::REG_STATUS, 0, 4'h2);
    bus(0, tif_pkg::REG_STATUS, 0, 4'hf);
    chk("clear ch1", 32'h1f33001f, rd);
    chk("irq ch1 off", 32'h0, {26'h0, irqs[1]});
    pulse(48'h0700);
    bus(0, tif_pkg::REG_STATUS, 0, 4'hf);
    chk("clear wins", 32'h1f33001f, rd);
    pulse(48'h0400);
    bus(1, tif_pkg::REG_STATUS, 0, 4'h2);
    bus(0, tif_pkg::REG_STATUS, 0, 4'hf);
    chk("unread kept", 32'h1f33101f, rd);
    bus(1, tif_pkg::REG_ENABLE, 0, 4'h1);
    bus(0, tif_pkg::REG_IRQ, 0, 4'hf);
    chk("irq lines", 32'h00f8f080, rd);
    gr_values[15:0] <= 16'h0005;
    counts[15:0] <= 16'h0005;
    bus(1, tif_pkg::REG_LEVEL, 32'h1, 4'h1);
    pulse(48'h08);
    chk("pin high", 32'h1, {31'h0, compare_pins[0]});
    counts[15:0] <= 16'h0006;
    bus(1, tif_pkg::REG_LEVEL, 32'h0, 4'h1);
    pulse(48'h08);
    chk("pin no match", 32'h1, {31'h0, compare_pins[0]});
    counts[15:0] <= 16'h0005;
    pulse(48'h08);
    chk("pin low", 32'h0, {31'h0, compare_pins[0]});
    bus(1, 4'h8, 0, 4'h1);
    accept <= 1'b0;
    pulse(48'h10_0000_0000);
    chk("not selected", 32'h6, {24'h0, n_conv});
    finish_test();
  end
endmodule
`default_nettype wire
